// [pkg/rds_readout_map.vh]
// Register indices, field positions and timing figures of the radio-data readout port.
// Assumes an AHB-Lite slave with 32-bit words; word index is haddr[7:2].
`ifndef RDS_READOUT_MAP_VH
`define RDS_READOUT_MAP_VH

// Word indices
`define IDX_CTRL      6'h00
`define IDX_STATUS    6'h01
`define IDX_LEVEL     6'h02
`define IDX_PERIOD    6'h03

// Control fields
`define CTRL_CLR      0

// Status fields
`define ST_READY      0
`define ST_SLAVE      1
`define ST_STBY       2
`define ST_FIRST      3
`define ST_QUAL       4
`define ST_OVF        5
`define ST_HOLD       6

// Half period of the master bit clock, in hclk cycles
`define PERIOD_RST    16'h0040
`define PERIOD_W      16

// Ready-check delay: longest time, rounded down to cycles
`define CLK_PERIOD_PS 8000
`define RDY_CHK_PS    750000
`define RDY_CHK_CYC   (`RDY_CHK_PS / `CLK_PERIOD_PS)

// Master clock sequencer states
`define MS_IDLE       2'b00
`define MS_HIGH       2'b01
`define MS_LOW        2'b10

`define AHB_OKAY      1'b0

`endif

// [rtl/rds_data_readout_port.v]
// Radio-data readout port: bit buffer with master and slave serial readout.
// Assumes a demodulator on hclk delivering bit strobes; pins arrive asynchronously.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rds_readout_map.vh"

module rds_data_readout_port #(
  parameter AW = 6
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // Demodulator side
  input  wire        demod_bit_valid,
  input  wire        demod_bit,
  input  wire        signal_quality_flag,
  // Pins
  input  wire        factory_select_pin,
  input  wire        mode_pin,
  input  wire        reset_pin,
  input  wire        bit_clock_pin_i,
  output reg         bit_clock_pin_o,
  output reg         bit_clock_pin_oe,
  output reg         serial_data_pin,
  output reg         flag_pin_o,
  output reg         flag_pin_oe,
  output reg         osc_stop
);

  localparam DEPTH = 1 << AW;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Pin synchronisers
  reg  [1:0]        rst_s_q;
  reg  [1:0]        mode_s_q;
  reg  [1:0]        fsel_s_q;
  reg  [1:0]        bclk_s_q;
  reg               bclk_prev_q;

  // Buffer
  reg               mem_q [0:DEPTH-1];
  reg  [AW-1:0]     wp_q;
  reg  [AW-1:0]     rp_q;
  reg  [AW:0]       cnt_q;

  // Detection state
  reg               quality_q;
  reg               first_q;
  reg               hold_q;
  reg               ovf_q;

  // Master sequencer
  reg  [1:0]        ms_q;
  reg  [15:0]       tick_q;

  // Registers
  reg               soft_clr_q;
  reg  [15:0]       period_q;
  reg               dp_wr_q;
  reg  [5:0]        dp_idx_q;

  wire              pin_rst;
  wire              is_slave;
  wire              is_master;
  wire              is_stby;
  wire              clr_all;
  wire              buf_clr;
  wire              empty;
  wire              full;
  wire              push;
  wire              s_pop;
  wire              m_pop;
  wire              pop;
  wire              ready;
  wire              bus_go;
  wire [5:0]        a_idx;
  wire [31:0]       status_w;
  reg  [31:0]       rd_mux;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s_q     <= 2'b00;
      mode_s_q    <= 2'b00;
      fsel_s_q    <= 2'b00;
      bclk_s_q    <= 2'b00;
      bclk_prev_q <= 1'b0;
    end else begin
      rst_s_q     <= {rst_s_q[0], reset_pin};
      mode_s_q    <= {mode_s_q[0], mode_pin};
      fsel_s_q    <= {fsel_s_q[0], factory_select_pin};
      bclk_s_q    <= {bclk_s_q[0], bit_clock_pin_i};
      bclk_prev_q <= bclk_s_q[1];
    end
  end

  assign pin_rst   = rst_s_q[1];
  assign is_master = ~fsel_s_q[1] & ~mode_s_q[1];
  assign is_slave  = ~fsel_s_q[1] & mode_s_q[1];
  // Test combination is left inert: no readout, pins released
  assign is_stby   = fsel_s_q[1] & ~mode_s_q[1];
  assign clr_all   = pin_rst | soft_clr_q;
  assign buf_clr   = clr_all & is_slave;
  assign empty     = (cnt_q == {(AW+1){1'b0}});
  assign full      = cnt_q[AW];
  assign push      = demod_bit_valid & first_q & ~clr_all & ~full;
  // Bit is consumed on the falling edge of the host bit clock
  assign s_pop     = is_slave & bclk_prev_q & ~bclk_s_q[1] & ~empty & ~buf_clr;
  assign m_pop     = is_master & ~hold_q & (ms_q == `MS_IDLE) & ~empty;
  assign pop       = s_pop | m_pop;
  assign ready     = first_q & ~empty;

  // Detection state and buffer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quality_q <= 1'b0;
      first_q   <= 1'b0;
      hold_q    <= 1'b1;
      ovf_q     <= 1'b0;
      wp_q      <= {AW{1'b0}};
      rp_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
    end else begin
      if (clr_all) begin
        quality_q <= 1'b0;
        first_q   <= 1'b0;
        hold_q    <= 1'b1;
      end else begin
        quality_q <= signal_quality_flag;
        if (signal_quality_flag) begin
          first_q <= 1'b1;
          hold_q  <= 1'b0;
        end
      end
      // A lost bit beats a software clear in the same cycle
      if (demod_bit_valid & first_q & ~clr_all & full)
        ovf_q <= 1'b1;
      else if (dp_wr_q && dp_idx_q == `IDX_STATUS && hwdata[`ST_OVF])
        ovf_q <= 1'b0;
      if (buf_clr) begin
        wp_q  <= {AW{1'b0}};
        rp_q  <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
      end else begin
        if (push)
          wp_q <= ptr_inc(wp_q);
        if (pop)
          rp_q <= ptr_inc(rp_q);
        if (push & ~pop)
          cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
        else if (pop & ~push)
          cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // Storage has no reset; contents are only read behind the count
  always @(posedge hclk) begin
    if (push)
      mem_q[wp_q] <= demod_bit;
  end

  // Master sequencer and pin drivers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_q             <= `MS_IDLE;
      tick_q           <= 16'h0000;
      bit_clock_pin_o  <= 1'b1;
      bit_clock_pin_oe <= 1'b0;
      serial_data_pin  <= 1'b1;
      flag_pin_o       <= 1'b0;
      flag_pin_oe      <= 1'b0;
      osc_stop         <= 1'b0;
    end else begin
      flag_pin_o <= 1'b0;
      osc_stop   <= is_stby;
      if (is_master) begin
        bit_clock_pin_oe <= 1'b1;
        flag_pin_oe      <= ~quality_q;
        if (hold_q) begin
          ms_q            <= `MS_IDLE;
          bit_clock_pin_o <= 1'b1;
          serial_data_pin <= 1'b1;
        end else begin
          case (ms_q)
            `MS_IDLE: begin
              if (m_pop) begin
                // Data and rising edge together; host takes it on the fall
                serial_data_pin <= mem_q[rp_q];
                bit_clock_pin_o <= 1'b1;
                tick_q          <= period_q - 16'h0001;
                ms_q            <= `MS_HIGH;
              end
              // Clock keeps its level here: a drop after hold would hand the host a phantom bit
            end
            `MS_HIGH: begin
              if (tick_q == 16'h0000) begin
                bit_clock_pin_o <= 1'b0;
                tick_q          <= period_q - 16'h0001;
                ms_q            <= `MS_LOW;
              end else begin
                tick_q <= tick_q - 16'h0001;
              end
            end
            `MS_LOW: begin
              if (tick_q == 16'h0000)
                ms_q <= `MS_IDLE;
              else
                tick_q <= tick_q - 16'h0001;
            end
            default: begin
              ms_q <= `MS_IDLE;
            end
          endcase
        end
      end else if (is_slave) begin
        // Head bit stands on the data pin; a switch in MS_HIGH loses the bit already popped when another bit follows it
        ms_q             <= `MS_IDLE;
        bit_clock_pin_oe <= 1'b0;
        bit_clock_pin_o  <= 1'b0;
        flag_pin_oe      <= ~(ready & ~buf_clr);
        if (~empty)
          serial_data_pin <= mem_q[rp_q];
      end else begin
        ms_q             <= `MS_IDLE;
        bit_clock_pin_oe <= 1'b0;
        bit_clock_pin_o  <= 1'b0;
        flag_pin_oe      <= 1'b0;
      end
    end
  end

  // AHB-Lite slave, zero wait states
  assign bus_go = hsel & hready & htrans[1];
  assign a_idx  = haddr[7:2];

  assign status_w = {25'h0, hold_q, ovf_q, quality_q, first_q,
                     is_stby, is_slave, ready};

  always @* begin
    case (a_idx)
      `IDX_CTRL:   rd_mux = 32'h00000000;
      `IDX_STATUS: rd_mux = status_w;
      `IDX_LEVEL:  rd_mux = {{(31-AW){1'b0}}, cnt_q};
      `IDX_PERIOD: rd_mux = {16'h0000, period_q};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout  <= 1'b1;
      hresp      <= `AHB_OKAY;
      hrdata     <= 32'h00000000;
      dp_wr_q    <= 1'b0;
      dp_idx_q   <= 6'h00;
      soft_clr_q <= 1'b0;
      period_q   <= `PERIOD_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `AHB_OKAY;
      dp_wr_q   <= bus_go & hwrite;
      dp_idx_q  <= a_idx;
      if (bus_go & ~hwrite)
        hrdata <= rd_mux;
      soft_clr_q <= dp_wr_q && dp_idx_q == `IDX_CTRL && hwdata[`CTRL_CLR];
      // Zero would stall the sequencer timing; it is refused
      if (dp_wr_q && dp_idx_q == `IDX_PERIOD && hwdata[15:0] != 16'h0000)
        period_q <= hwdata[15:0];
    end
  end

endmodule // rds_data_readout_port

`default_nettype wire

// [bench/rds_readout_asserts.sv]
// Checker for the readout port pins.
// Assumes pins stay put long enough to pass the input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module rds_readout_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Demodulator and pins
  input wire logic demod_bit_valid,
  input wire logic signal_quality_flag,
  input wire logic factory_select_pin,
  input wire logic mode_pin,
  input wire logic reset_pin,
  input wire logic bit_clock_pin_i,
  input wire logic bit_clock_pin_o,
  input wire logic bit_clock_pin_oe,
  input wire logic serial_data_pin,
  input wire logic flag_pin_oe,
  input wire logic osc_stop
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic mst = !factory_select_pin && !mode_pin;
  wire logic slv = !factory_select_pin && mode_pin;
  property p_stby; (factory_select_pin && !mode_pin)[*6] |-> osc_stop; endproperty
  a_stby: assert property (p_stby) else $error("standby missed");
  property p_mdrv; mst[*6] |-> bit_clock_pin_oe; endproperty
  a_mdrv: assert property (p_mdrv) else $error("clock not driven");
  property p_sdrv; slv[*6] |-> !bit_clock_pin_oe; endproperty
  a_sdrv: assert property (p_sdrv) else $error("clock driven in slave");
  property p_hold; (mst && reset_pin && !signal_quality_flag)[*6] |-> bit_clock_pin_o && serial_data_pin; endproperty
  a_hold: assert property (p_hold) else $error("pins not held high");
  property p_qual; (mst && !reset_pin && $stable(signal_quality_flag))[*6] |-> flag_pin_oe == !signal_quality_flag;
  endproperty
  a_qual: assert property (p_qual) else $error("flag wrong");
  property p_rclr; (slv && reset_pin)[*4] |-> flag_pin_oe; endproperty
  a_rclr: assert property (p_rclr) else $error("ready not cleared");
  property p_rrise; (slv && !signal_quality_flag)[*6] ##1 $fell(flag_pin_oe)
    |-> $past(demod_bit_valid, 1) || $past(demod_bit_valid, 2) || $past(demod_bit_valid, 3); endproperty
  a_rrise: assert property (p_rrise) else $error("ready rose without bit");
  property p_dstab; (slv && bit_clock_pin_i && !flag_pin_oe)[*6] |=> $stable(serial_data_pin); endproperty
  a_dstab: assert property (p_dstab) else $error("data moved with clock high");
endmodule // rds_readout_asserts
bind rds_data_readout_port rds_readout_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .demod_bit_valid(demod_bit_valid), .signal_quality_flag(signal_quality_flag),
  .factory_select_pin(factory_select_pin), .mode_pin(mode_pin), .reset_pin(reset_pin),
  .bit_clock_pin_i(bit_clock_pin_i), .bit_clock_pin_o(bit_clock_pin_o), .bit_clock_pin_oe(bit_clock_pin_oe),
  .serial_data_pin(serial_data_pin), .flag_pin_oe(flag_pin_oe), .osc_stop(osc_stop));
`default_nettype wire

// [bench/rds_host_model.sv]
// Host controller model: captures master bits, clocks slave bits.
// Assumes ready is the pulled-up flag pin level.
`timescale 1ns/1ps
`default_nettype none
module rds_host_model #(parameter int HALF = 96) (
  // Clock
  input wire logic hclk,
  // Pins
  input wire logic rdy,
  input wire logic sdata,
  input wire logic mclk,
  output var logic sclk
);
  logic mclk_q = 1'b0;
  logic [31:0] cap = 32'h0;
  int ncap = 0;
  initial sclk = 1'b0;
  always @(posedge hclk) begin
    mclk_q <= mclk;
    if (mclk_q && !mclk) begin
      cap <= {cap[30:0], sdata};
      ncap <= ncap + 1;
    end
  end
  // Clock stays low while ready is low; caller checks ready after the low half
  task automatic rd(output logic b);
    while (rdy !== 1'b1) @(posedge hclk);
    sclk <= 1'b1;
    repeat (HALF) @(posedge hclk);
    b = sdata;
    sclk <= 1'b0;
    repeat (HALF) @(posedge hclk);
  endtask
endmodule // rds_host_model
`default_nettype wire

// [bench/testbench.sv]
// Bench for the readout port: bus tasks, demodulator strobes, pin sequences.
// Assumes open-drain flag with pull-up and a shared bit clock pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, dv = 1'b0, db = 1'b0, qual = 1'b0;
  logic fsel = 1'b0, mode = 1'b0, rst_pin = 1'b0, b;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, clk_o, clk_oe, sdata, flag_o, flag_oe, osc_stop, host_clk;
  wire logic clk_pin = clk_oe ? clk_o : host_clk;
  int errors = 0, checked = 0, n0 = 0;
  always #4 hclk = ~hclk;
  rds_data_readout_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .demod_bit_valid(dv), .demod_bit(db),
    .signal_quality_flag(qual), .factory_select_pin(fsel), .mode_pin(mode), .reset_pin(rst_pin),
    .bit_clock_pin_i(clk_pin), .bit_clock_pin_o(clk_o), .bit_clock_pin_oe(clk_oe),
    .serial_data_pin(sdata), .flag_pin_o(flag_o), .flag_pin_oe(flag_oe), .osc_stop(osc_stop));
  rds_host_model host (.hclk(hclk), .rdy(!flag_oe), .sdata(sdata), .mclk(clk_o & clk_oe), .sclk(host_clk));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic push(input logic v);
    @(posedge hclk);
    dv <= 1'b1; db <= v;
    @(posedge hclk);
    dv <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(20000);
    errors++;
    print_verdict();
  end
  initial begin
    cyc(16);
    hresetn <= 1'b1;
    cyc(4);
    chk("hresp", hresp, 0);
    chk("hreadyout", hreadyout, 1);
    ahb(1, 32'hc, 32'h2, r);
    ahb(0, 32'hc, 0, r);
    chk("period", r, 2);
    ahb(0, 32'h40, 0, r);
    chk("unmapped", r, 0);
    rst_pin <= 1'b1;
    cyc(10);
    rst_pin <= 1'b0;
    push(1); push(0);
    cyc(20);
    chk("hold", {clk_o, sdata}, 2'h3);
    ahb(0, 32'h8, 0, r);
    chk("level", r, 0);
    qual <= 1'b1;
    cyc(8);
    chk("flag", !flag_oe, 1);
    push(1); push(0); push(1); push(1);
    cyc(60);
    chk("master bits", {host.ncap[7:0], host.cap[3:0]}, 12'h04b);
    qual <= 1'b0;
    mode <= 1'b1;
    cyc(10);
    chk("oe", clk_oe, 0);
    push(0); push(1); push(1);
    cyc(8);
    chk("ready", !flag_oe, 1);
    for (int i = 0; i < 3; i++) begin
      host.rd(b);
      chk("slave bit", b, (i > 0));
    end
    chk("ready", !flag_oe, 0);
    push(1); push(0);
    rst_pin <= 1'b1;
    cyc(8);
    chk("ready", !flag_oe, 0);
    rst_pin <= 1'b0;
    push(1);
    cyc(6);
    ahb(0, 32'h8, 0, r);
    chk("level", r, 0);
    fsel <= 1'b1;
    mode <= 1'b0;
    cyc(8);
    chk("standby", osc_stop, 1);
    fsel <= 1'b0;
    cyc(8);
    chk("standby", osc_stop, 0);
    chk("flag drive", flag_o, 0);
    ahb(1, 32'hc, 32'h40, r);
    qual <= 1'b1;
    cyc(8);
    n0 = host.ncap;
    push(1); push(0); push(1);
    while (host.ncap == n0) @(posedge hclk);
    mode <= 1'b1;
    cyc(8);
    ahb(0, 32'h4, 0, r);
    chk("status", r, 32'h1b);
    host.rd(b);
    chk("switch bit", b, 0);
    host.rd(b);
    chk("switch bit", b, 1);
    push(1);
    host.rd(b);
    chk("switch bit", b, 1);
    mode <= 1'b0;
    push(0);
    while (host.ncap == n0 + 1) @(posedge hclk);
    chk("master count", host.ncap - n0, 2);
    chk("master bits", host.cap[1:0], 2'h2);
    qual <= 1'b0;
    ahb(1, 32'h0, 32'h1, r);
    ahb(0, 32'h4, 0, r);
    chk("status", r, 32'h40);
    cyc(4);
    chk("hold", {clk_o, sdata}, 2'h3);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
